// *** bench/pbs_host_model.sv ***
// Cache controller model issuing commands to the burst static RAM
`timescale 1ns/10ps
`default_nettype none
`include "pbs_consts.vh"
module pbs_host_model (
  input  wire logic               sys_clk_in,
  output logic [`PBS_ADDR_W-1:0] addr_in,
  output logic [`PBS_DATA_W-1:0] byte_lane_in,
  output logic [`PBS_LANES-1:0]  lane_write_sel_n_in,
  output logic clk_en_in, ctrl_addr_strobe_n_in, proc_addr_strobe_n_in, burst_step_n_in,
  output logic all_lanes_write_n_in, lane_write_qual_n_in, chip_en_primary_n_in,
  output logic chip_en_expand_hi_in, chip_en_expand_lo_n_in, burst_order_sel_in,
  output logic sleep_req_in, out_en_n_in
);
  // ********************
  // Bus driving
  // ********************
  // Idle bus, expansion enables active
  initial begin
    {addr_in, byte_lane_in, lane_write_sel_n_in} = '0;
    {clk_en_in, ctrl_addr_strobe_n_in, proc_addr_strobe_n_in, burst_step_n_in} = 4'hf;
    {all_lanes_write_n_in, lane_write_qual_n_in, chip_en_primary_n_in} = 3'h6;
    {chip_en_expand_hi_in, chip_en_expand_lo_n_in} = 2'h2;
    {burst_order_sel_in, sleep_req_in, out_en_n_in} = 3'h1;
  end
  // One command edge; c is {ctrl, proc, primary, global, qualifier, advance}
  task automatic cmd(input logic [`PBS_ADDR_W-1:0] a, input logic [5:0] c,
                     input logic [`PBS_LANES-1:0] s_n, input logic [`PBS_DATA_W-1:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    {ctrl_addr_strobe_n_in, proc_addr_strobe_n_in, chip_en_primary_n_in} <= c[5:3];
    {all_lanes_write_n_in, lane_write_qual_n_in, burst_step_n_in} <= c[2:0];
    lane_write_sel_n_in <= s_n;
    byte_lane_in <= d;
  endtask
  // Edges with no strobe, advance as given
  task automatic idle(input logic st_n, input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      {ctrl_addr_strobe_n_in, proc_addr_strobe_n_in, burst_step_n_in} <= {2'h3, st_n};
    end
  endtask
  // Deselect by primary enable; released data shown inverted
  task automatic desel();
    cmd(addr_in, 6'b011111, 4'hf, ~byte_lane_in);
  endtask
  // Order moves only between bursts
  task automatic side(input logic o, z, g);
    @(posedge sys_clk_in);
    {burst_order_sel_in, sleep_req_in, out_en_n_in} <= {o, z, g};
  endtask
endmodule // pbs_host_model
`default_nettype wire

// *** bench/pbs_sram_asserts.sv ***
// Port timing checker for the burst static RAM core
`timescale 1ns/10ps
`default_nettype none
`include "pbs_consts.vh"
module pbs_sram_asserts (
  input wire logic sys_clk_in, reset_n_in, clk_en_in, ctrl_addr_strobe_n_in,
  input wire logic proc_addr_strobe_n_in, burst_step_n_in, chip_en_primary_n_in,
  input wire logic sleep_req_in, out_en_n_in, low_power_out,
  input wire logic [`PBS_DATA_W-1:0] byte_lane_out,
  input wire logic [`PBS_LANES-1:0]  byte_lane_oe_out
);
  // ********************
  // Port relations
  // ********************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Awake, idle bus and steady output enable over three edges
  sequence s_awake; !sleep_req_in [*3]; endsequence
  sequence s_quiet;
    (ctrl_addr_strobe_n_in && proc_addr_strobe_n_in && burst_step_n_in && clk_en_in) [*3];
  endsequence
  sequence s_oe_held; (out_en_n_in == $past(out_en_n_in)) [*3]; endsequence
  property p_oe_equal; byte_lane_oe_out == 4'h0 || byte_lane_oe_out == 4'hf; endproperty
  a_oe_equal: assert property (p_oe_equal) else $error("lane enables differ");
  property p_oe_cause;
    byte_lane_oe_out != 4'h0 |-> !$past(out_en_n_in, 2) || !$past(out_en_n_in, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("lanes driven, no enable");
  property p_desel;
    s_awake ##0 (clk_en_in && !ctrl_addr_strobe_n_in && chip_en_primary_n_in)
      |=> ##1 byte_lane_oe_out == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect left lanes on");
  property p_suspend; s_quiet |=> $stable(byte_lane_out); endproperty
  a_suspend: assert property (p_suspend) else $error("read data moved");
  property p_proc_ign;
    s_awake ##0 s_oe_held ##0 (clk_en_in && ctrl_addr_strobe_n_in && !proc_addr_strobe_n_in
      && chip_en_primary_n_in && burst_step_n_in) |=> ##1 $stable(byte_lane_oe_out);
  endproperty
  a_proc_ign: assert property (p_proc_ign) else $error("blocked strobe acted");
  property p_sleep_hiz; sleep_req_in [*4] |-> byte_lane_oe_out == 4'h0; endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("lanes on in sleep");
  property p_lp_hold;
    (ctrl_addr_strobe_n_in && proc_addr_strobe_n_in) [*2] ##0 low_power_out |=> low_power_out;
  endproperty
  a_lp_hold: assert property (p_lp_hold) else $error("low power left early");
  property p_lp_cause;
    $rose(low_power_out) |-> $past(sleep_req_in, 2) || $past(sleep_req_in, 3)
      || $past(sleep_req_in, 4);
  endproperty
  a_lp_cause: assert property (p_lp_cause) else $error("low power, no sleep");
endmodule // pbs_sram_asserts
`default_nettype wire

// *** bench/pipelined_burst_sync_sram_tb_top.sv ***
// Top testbench for the burst static RAM core
`timescale 1ns/10ps
`default_nettype none
`include "pbs_consts.vh"
module pipelined_burst_sync_sram_tb_top;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  wire [`PBS_ADDR_W-1:0] addr_in;
  wire [`PBS_DATA_W-1:0] byte_lane_in, byte_lane_out;
  wire [`PBS_LANES-1:0]  lane_write_sel_n_in, byte_lane_oe_out;
  wire clk_en_in, ctrl_addr_strobe_n_in, proc_addr_strobe_n_in, burst_step_n_in;
  wire all_lanes_write_n_in, lane_write_qual_n_in, chip_en_primary_n_in, low_power_out;
  wire chip_en_expand_hi_in, chip_en_expand_lo_n_in, burst_order_sel_in, sleep_req_in;
  wire out_en_n_in;
  int  n_errors = 0;
  int  n_compared = 0;
  // ********************
  // Clock, instances, tasks
  // ********************
  always #5 sys_clk_in = ~sys_clk_in;
  pbs_sram_core pbs_sram_core_i (.*);
  pbs_host_model pbs_host_model_i (.*);
  // Compare and count
  task automatic check(input logic [`PBS_DATA_W-1:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Back-to-back writes, output enable negated first
  task automatic t_writes();
    pbs_host_model_i.side(1'b0, 1'b0, 1'b1);
    pbs_host_model_i.cmd(16'h0100, 6'b010011, 4'hf, 32'h11223344);
    pbs_host_model_i.cmd(16'h0101, 6'b010101, 4'h0, 32'haabbccdd);
    pbs_host_model_i.cmd(16'h0102, 6'b010001, 4'he, 32'h01020304);
    pbs_host_model_i.cmd(16'h0103, 6'b010011, 4'hf, 32'h0a0b0c0d);
    pbs_host_model_i.cmd(16'h0100, 6'b010101, 4'ha, 32'hffffffff);
    pbs_host_model_i.desel();
    $display("test writes done");
  endtask
  // Burst of four, each word checked as it leaves the output register
  task automatic t_burst(input logic [15:0] a, input logic pr, ord, input logic [127:0] e);
    int i;
    pbs_host_model_i.side(ord, 1'b0, 1'b0);
    pbs_host_model_i.idle(1'b1, 3);
    pbs_host_model_i.cmd(a, pr ? 6'b100110 : 6'b010110, 4'hf, 32'h0);
    pbs_host_model_i.idle(1'b0, 1);
    for (i = 0; i < 4; i++) begin
      pbs_host_model_i.idle(1'b0, 1);
      #1;
      check(byte_lane_out, e[127-32*i -: 32]);
    end
    check({28'h0, byte_lane_oe_out}, 32'hf);
    pbs_host_model_i.desel();
    $display("test burst %h done", a);
  endtask
  // Blocked processor strobe during a suspended read
  task automatic t_proc_ign();
    pbs_host_model_i.cmd(16'h0102, 6'b010111, 4'hf, 32'h0);
    pbs_host_model_i.cmd(16'h0100, 6'b101111, 4'hf, 32'h0);
    pbs_host_model_i.idle(1'b1, 2);
    #1;
    check(byte_lane_out, 32'h01020304);
    pbs_host_model_i.desel();
    $display("test blocked strobe done");
  endtask
  // Sleep, release, then a read wakes the array with data kept
  task automatic t_sleep();
    pbs_host_model_i.side(1'b0, 1'b1, 1'b0);
    pbs_host_model_i.idle(1'b1, 6);
    #1;
    check({31'h0, low_power_out}, 32'h1);
    pbs_host_model_i.side(1'b0, 1'b0, 1'b0);
    pbs_host_model_i.idle(1'b1, 5);
    #1;
    check({31'h0, low_power_out}, 32'h1);
    t_burst(16'h0103, 1'b0, 1'b0, {32'h0a0b0c0d, 32'h11ff33ff, 32'haabbccdd, 32'h01020304});
    check({31'h0, low_power_out}, 32'h0);
    $display("test sleep done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_writes();
    t_burst(16'h0101, 1'b0, 1'b0, {32'haabbccdd, 32'h01020304, 32'h0a0b0c0d, 32'h11ff33ff});
    t_burst(16'h0101, 1'b1, 1'b1, {32'haabbccdd, 32'h11ff33ff, 32'h0a0b0c0d, 32'h01020304});
    t_proc_ign();
    t_sleep();
    conclude();
  end
  // Hang guard
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
endmodule // pipelined_burst_sync_sram_tb_top
bind pbs_sram_core pbs_sram_asserts pbs_sram_asserts_i (.*);
`default_nettype wire

// *** hw/pbs_burst_ctr.v ***
// Two-bit burst address counter with linear or interleaved order
`timescale 1ns/10ps
`default_nettype none
`include "pbs_consts.vh"
module pbs_burst_ctr (
  input  wire                    sys_clk_in,
  input  wire                    reset_n_in,
  input  wire                    clk_en_in,
  input  wire                    load_in,
  input  wire                    step_in,
  input  wire [`PBS_BURST_W-1:0] start_in,
  input  wire                    interleave_in,
  output wire [`PBS_BURST_W-1:0] low_addr_out
);
  reg [`PBS_BURST_W-1:0] start_q;
  reg [`PBS_BURST_W-1:0] count_q;

  // ************************************************************
  // Count and start bits
  // ************************************************************
  // Load start bits on a strobe, step on advance, else hold
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_q <= 2'h0;
      count_q <= 2'h0;
    end else if (clk_en_in) begin
      if (load_in) begin
        start_q <= start_in;
        count_q <= 2'h0;
      end else if (step_in) begin
        count_q <= count_q + 2'h1;
      end
    end
  end

  // Wrap in a four-word group: add for linear, xor for interleaved
  assign low_addr_out = interleave_in ? (start_q ^ count_q) :
                        (start_q + count_q);
endmodule // pbs_burst_ctr
`default_nettype wire

// *** hw/pbs_consts.vh ***
// Constants for the pipelined burst synchronous static RAM core
`ifndef PBS_CONSTS_VH
`define PBS_CONSTS_VH
`define PBS_ADDR_W   16
`define PBS_DATA_W   32
`define PBS_LANES    4
`define PBS_LANE_W   8
`define PBS_DEPTH    65536
`define PBS_BURST_W  2
`endif

// *** hw/pbs_sram_core.v ***
// Pipelined burst synchronous static RAM, 64K words of 32 bits
`timescale 1ns/10ps
`default_nettype none
`include "pbs_consts.vh"
module pbs_sram_core (
  input  wire                   sys_clk_in,
  input  wire                   reset_n_in,
  input  wire                   clk_en_in,
  input  wire [`PBS_ADDR_W-1:0] addr_in,
  input  wire                   ctrl_addr_strobe_n_in,
  input  wire                   proc_addr_strobe_n_in,
  input  wire                   burst_step_n_in,
  input  wire [`PBS_LANES-1:0]  lane_write_sel_n_in,
  input  wire                   all_lanes_write_n_in,
  input  wire                   lane_write_qual_n_in,
  input  wire                   chip_en_primary_n_in,
  input  wire                   chip_en_expand_hi_in,
  input  wire                   chip_en_expand_lo_n_in,
  input  wire                   burst_order_sel_in,
  input  wire                   sleep_req_in,
  input  wire                   out_en_n_in,
  input  wire [`PBS_DATA_W-1:0] byte_lane_in,
  output wire [`PBS_DATA_W-1:0] byte_lane_out,
  output wire [`PBS_LANES-1:0]  byte_lane_oe_out,
  output wire                   low_power_out
);
  // ************************************************************
  // Declarations
  // ************************************************************
  localparam ST_IDLE  = 2'h0;
  localparam ST_READ  = 2'h1;
  localparam ST_WRITE = 2'h2;

  reg [`PBS_DATA_W-1:0] mem [0:`PBS_DEPTH-1];
  reg [1:0]             state_q;
  reg [1:0]             state_d;
  reg [`PBS_ADDR_W-1:0] addr_q;
  reg [`PBS_DATA_W-1:0] rd_q;
  reg                   rd_valid_q;
  reg                   sleep_s1_q;
  reg                   sleep_s2_q;
  reg                   low_power_q;
  reg                   oe_s1_q;
  reg                   oe_s2_q;
  reg                   order_s1_q;
  reg                   order_s2_q;
  wire                  run;
  wire                  all_en;
  wire                  ctrl_go;
  wire                  proc_go;
  wire                  proc_ok;
  wire                  load;
  wire                  wr_req;
  wire [`PBS_LANES-1:0] wr_lanes;
  wire [1:0]            low_bits;
  wire [`PBS_ADDR_W-1:0] cur_addr;
  wire                  cur_write;

  // ************************************************************
  // Pin synchronisers for asynchronous inputs
  // ************************************************************
  // Two stages for sleep, output enable and order pins
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
      oe_s1_q    <= 1'b1;
      oe_s2_q    <= 1'b1;
      order_s1_q <= 1'b0;
      order_s2_q <= 1'b0;
    end else if (clk_en_in) begin
      sleep_s1_q <= sleep_req_in;
      sleep_s2_q <= sleep_s1_q;
      oe_s1_q    <= out_en_n_in;
      oe_s2_q    <= oe_s1_q;
      order_s1_q <= burst_order_sel_in;
      order_s2_q <= order_s1_q;
    end
  end

  // Sleep freezes all core state except the pin synchronisers and low power flag, like a stopped clock
  assign run = clk_en_in & ~sleep_s2_q;

  // ************************************************************
  // Decode functions
  // ************************************************************
  // Lanes written this edge; global write wins over lane selects
  function [`PBS_LANES-1:0] lane_mask;
    input                  all_n;
    input                  qual_n;
    input [`PBS_LANES-1:0] sel_n;
    begin
      if (!all_n) begin
        lane_mask = 4'hf;
      end else if (!qual_n) begin
        lane_mask = ~sel_n;
      end else begin
        lane_mask = 4'h0;
      end
    end
  endfunction

  // Cycle that a taken strobe begins: deselect, read or write
  function [1:0] begin_cycle;
    input en;
    input proc;
    input wr;
    begin
      if (!en) begin
        begin_cycle = ST_IDLE;
      end else if (proc) begin
        begin_cycle = ST_READ;
      end else if (wr) begin
        begin_cycle = ST_WRITE;
      end else begin
        begin_cycle = ST_READ;
      end
    end
  endfunction

  // True while the cycle state reads the array
  function is_read;
    input [1:0] st;
    begin
      is_read = (st == ST_READ);
    end
  endfunction

  // ************************************************************
  // Strobe and enable decoding
  // ************************************************************
  assign all_en  = ~chip_en_primary_n_in & chip_en_expand_hi_in &
                   ~chip_en_expand_lo_n_in;
  // Processor strobe ignored when primary enable is high
  assign proc_ok = ~proc_addr_strobe_n_in & ~chip_en_primary_n_in;
  // Controller strobe counts only when processor strobe is not taken
  assign ctrl_go = ~ctrl_addr_strobe_n_in & ~proc_ok;
  assign proc_go = proc_ok;
  assign load    = proc_go | ctrl_go;
  // Write request: at least one lane selected by the lane decode
  assign wr_req   = |lane_mask(all_lanes_write_n_in, lane_write_qual_n_in,
                               lane_write_sel_n_in);
  // Global write overrides lane selects
  assign wr_lanes = lane_mask(all_lanes_write_n_in, lane_write_qual_n_in,
                              lane_write_sel_n_in);

  // ************************************************************
  // Cycle state machine
  // ************************************************************
  // Next cycle: deselect, begin read, begin write or continue
  // A taken strobe always restarts; otherwise an active cycle goes to write on a write request, else read
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (load) begin
          state_d = begin_cycle(all_en, proc_go, wr_req);
        end
      end
      ST_READ, ST_WRITE: begin
        if (load) begin
          state_d = begin_cycle(all_en, proc_go, wr_req);
        end else begin
          state_d = wr_req ? ST_WRITE : ST_READ;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Register state and external address
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      addr_q  <= 16'h0000;
    end else if (run) begin
      state_q <= state_d;
      if (load) begin
        addr_q <= addr_in;
      end
    end
  end

  // ************************************************************
  // Burst counter
  // ************************************************************
  pbs_burst_ctr u_burst_ctr (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (run),
    .load_in       (load & all_en),
    .step_in       (~load & ~burst_step_n_in),
    .start_in      (addr_in[1:0]),
    .interleave_in (order_s2_q),
    .low_addr_out  (low_bits)
  );

  assign cur_addr  = {addr_q[`PBS_ADDR_W-1:2], low_bits};
  assign cur_write = (state_q == ST_WRITE);

  // ************************************************************
  // Array access and read pipeline
  // ************************************************************
  // Per-lane write of the captured data at the clock edge
  reg [`PBS_DATA_W-1:0] wdata_q;
  reg [`PBS_LANES-1:0]  wlanes_q;
  integer i;
  always @(posedge sys_clk_in) begin
    if (run && cur_write) begin
      for (i = 0; i < `PBS_LANES; i = i + 1) begin
        if (wlanes_q[i]) begin
          mem[cur_addr][i*`PBS_LANE_W +: `PBS_LANE_W] <=
            wdata_q[i*`PBS_LANE_W +: `PBS_LANE_W];
        end
      end
    end
  end

  // Capture write data and lanes with the controls
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wdata_q  <= 32'h00000000;
      wlanes_q <= 4'h0;
    end else if (run) begin
      wdata_q  <= byte_lane_in;
      wlanes_q <= wr_lanes;
    end
  end

  // Output register: one cycle of pipeline latency
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_q       <= 32'h00000000;
      rd_valid_q <= 1'b0;
    end else if (run) begin
      rd_valid_q <= is_read(state_q);
      if (is_read(state_q)) begin
        rd_q <= mem[cur_addr];
      end
    end
  end

  // ************************************************************
  // Low power tracking
  // ************************************************************
  // Stays low power after sleep until a read or write begins
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      low_power_q <= 1'b0;
    end else if (clk_en_in) begin
      if (sleep_s2_q) begin
        low_power_q <= 1'b1;
      end else if (load && all_en) begin
        low_power_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Lane drivers
  // ************************************************************
  // Drive only a read that left the output register, never in sleep;
  // the write term keeps lanes released while host data is captured
  assign byte_lane_out    = rd_q;
  assign byte_lane_oe_out = {`PBS_LANES{rd_valid_q & ~oe_s2_q & ~sleep_s2_q &
                            ~cur_write}};
  assign low_power_out    = low_power_q;
endmodule // pbs_sram_core
`default_nettype wire
